// File: rtl/otg_global_pkg.sv
// Constants and carriers for the global control and configuration block.
// Assumes word-wide register access at the fixed byte offsets.
package otg_global_pkg;
    localparam logic [11:0] OFS_STATUS_CTRL = 12'h000;
    localparam logic [11:0] OFS_EVENT_STAT  = 12'h004;
    localparam logic [11:0] OFS_BUS_CFG     = 12'h008;
    localparam logic [11:0] OFS_USB_CFG     = 12'h00C;
    localparam int BIT_ROLE      = 21;
    localparam int BIT_IDENT     = 16;
    localparam int BIT_SESS_END  = 2;
    localparam int BIT_PER_THR   = 8;
    localparam int BIT_NP_THR    = 7;
    localparam int BIT_GATE      = 0;
    localparam int BIT_CORRUPT   = 31;
    localparam int BIT_FORCE_DEV = 30;
    localparam int BIT_FORCE_HST = 29;
    localparam int POS_TURN      = 10;
    localparam int POS_TOUT      = 0;
    localparam logic [3:0] TURN_RESET = 4'h5;
    localparam logic [2:0] TOUT_RESET = 3'h0;
    localparam int FS_BIT_QUARTERS_MIN = 64;
    localparam int FS_BIT_QUARTERS_MAX = 72;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       per_thr;
        logic       np_thr;
        logic       gate;
        logic       corrupt;
        logic       force_dev;
        logic       force_hst;
        logic [3:0] turn;
        logic [2:0] tout;
    } cfg_t;
endpackage

// File: rtl/otg_cfg_store.sv
// Configuration register store for the two writable words.
// Assumes a decoded word write with its data.
`timescale 1ns/100ps
`default_nettype none
module otg_cfg_store
    import otg_global_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   wr_bus,
    input  wire logic                   wr_usb,
    input  wire logic [31:0]            wdata,
    output var otg_global_pkg::cfg_t    cfg
);
    cfg_t cfg_q;
    cfg_t cfg_d;

    always_comb begin
        cfg_d = cfg_q;
        if (wr_bus) begin
            cfg_d.per_thr = wdata[BIT_PER_THR];
            cfg_d.np_thr  = wdata[BIT_NP_THR];
            cfg_d.gate    = wdata[BIT_GATE];
        end
        if (wr_usb) begin
            cfg_d.corrupt   = wdata[BIT_CORRUPT];
            cfg_d.force_dev = wdata[BIT_FORCE_DEV];
            cfg_d.force_hst = wdata[BIT_FORCE_HST];
            cfg_d.turn      = wdata[POS_TURN +: 4];
            cfg_d.tout      = wdata[POS_TOUT +: 3];
        end
    end

    // No role input: contents survive mode switches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '{per_thr: 1'b0, np_thr: 1'b0, gate: 1'b0,
                       corrupt: 1'b0, force_dev: 1'b0, force_hst: 1'b0,
                       turn: TURN_RESET, tout: TOUT_RESET};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg = cfg_q;
endmodule
`default_nettype wire

// File: rtl/otg_session_flag.sv
// Sticky session-end flag, set by hardware, write-one-to-clear.
// Assumes bus_valid synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module otg_session_flag (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic bus_valid,
    input  wire logic clr_one,
    output logic      session_end_flag
);
    logic vld_q;
    logic vld_d;
    logic flag_q;
    logic flag_d;
    logic fall;

    always_comb begin
        vld_d  = bus_valid;
        fall   = vld_q && !bus_valid;
        flag_d = flag_q;
        if (clr_one) begin
            flag_d = 1'b0;
        end
        if (fall) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vld_q  <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            vld_q  <= vld_d;
            flag_q <= flag_d;
        end
    end

    assign session_end_flag = flag_q;

    property p_set_on_fall;
        @(posedge clk) disable iff (!rstn)
        (vld_q && !bus_valid) |=> flag_q;
    endproperty
    a_set_on_fall: assert property (p_set_on_fall)
        else $error("session flag not set on bus-valid loss");

    property p_no_sw_set;
        @(posedge clk) disable iff (!rstn)
        (!flag_q && !(vld_q && !bus_valid)) |=> !flag_q;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("session flag set without event");

    property p_zero_keeps;
        @(posedge clk) disable iff (!rstn)
        (flag_q && !clr_one) |=> flag_q;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("session flag lost without clear");
endmodule
`default_nettype wire

// File: rtl/otg_global_regs.sv
// Global control and configuration registers of the OTG controller.
// Assumes a one-cycle register request port and synchronous status inputs.
`timescale 1ns/100ps
`default_nettype none
module otg_global_regs
    import otg_global_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire otg_global_pkg::reg_req_t  req,
    output logic [31:0]                    rdata,
    output logic                           rvalid,
    input  wire logic                      id_pin,
    input  wire logic                      bus_valid,
    input  wire logic                      core_irq,
    input  wire logic                      per_fifo_half,
    input  wire logic                      per_fifo_full_empty,
    input  wire logic                      per_queue_room,
    input  wire logic                      np_fifo_half,
    input  wire logic                      np_fifo_full_empty,
    output logic                           irq,
    output logic                           host_role,
    output logic                           periodic_fifo_empty_irq,
    output logic                           nonperiodic_fifo_empty_irq,
    output logic                           in_endpoint_fifo_empty_irq,
    output logic                           corrupt_packet_debug,
    output logic [3:0]                     turnaround_clocks,
    output logic [7:0]                     timeout_quarters_min,
    output logic [7:0]                     timeout_quarters_max
);
    cfg_t        cfg;
    logic        wr_bus;
    logic        wr_usb;
    logic        clr_one;
    logic        session_end_flag;
    logic        ident_q;
    logic        ident_d;
    logic        role_q;
    logic        role_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    function automatic logic [31:0] one_bit(input int pos, input logic v);
        logic [31:0] w;
        w      = 32'h0000_0000;
        w[pos] = v;
        return w;
    endfunction

    function automatic logic hit(input reg_req_t r, input logic [11:0] ofs);
        return r.valid && r.write && (r.addr == ofs);
    endfunction

    function automatic logic empty_level(input logic full_sel,
                                         input logic half,
                                         input logic full);
        return full_sel ? full : half;
    endfunction

    assign wr_bus  = hit(req, OFS_BUS_CFG);
    assign wr_usb  = hit(req, OFS_USB_CFG);
    assign clr_one = hit(req, OFS_EVENT_STAT) && req.wdata[BIT_SESS_END];

    otg_cfg_store u_cfg (
        .clk    (clk),
        .rstn   (rstn),
        .wr_bus (wr_bus),
        .wr_usb (wr_usb),
        .wdata  (req.wdata),
        .cfg    (cfg)
    );

    otg_session_flag u_sess (
        .clk              (clk),
        .rstn             (rstn),
        .bus_valid        (bus_valid),
        .clr_one          (clr_one),
        .session_end_flag (session_end_flag)
    );

    // Role selection and identity tracking
    always_comb begin
        ident_d = id_pin;
        if (cfg.force_dev) begin
            role_d = 1'b0;
        end else if (cfg.force_hst) begin
            role_d = 1'b1;
        end else begin
            role_d = !id_pin;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ident_q <= 1'b1;
            role_q  <= 1'b0;
        end else begin
            ident_q <= ident_d;
            role_q  <= role_d;
        end
    end

    // Read path; unmapped and reserved bits read zero
    always_comb begin
        rvalid_d = req.valid && !req.write;
        rdata_d  = 32'h0000_0000;
        if (req.addr == OFS_STATUS_CTRL) begin
            rdata_d = one_bit(BIT_ROLE, role_q)
                    | one_bit(BIT_IDENT, ident_q);
        end else if (req.addr == OFS_EVENT_STAT) begin
            rdata_d = one_bit(BIT_SESS_END, session_end_flag);
        end else if (req.addr == OFS_BUS_CFG) begin
            rdata_d = one_bit(BIT_PER_THR, cfg.per_thr)
                    | one_bit(BIT_NP_THR, cfg.np_thr)
                    | one_bit(BIT_GATE, cfg.gate);
        end else if (req.addr == OFS_USB_CFG) begin
            rdata_d = one_bit(BIT_CORRUPT, cfg.corrupt)
                    | one_bit(BIT_FORCE_DEV, cfg.force_dev)
                    | one_bit(BIT_FORCE_HST, cfg.force_hst);
            rdata_d[POS_TURN +: 4] = cfg.turn;
            rdata_d[POS_TOUT +: 3] = cfg.tout;
        end
        if (!rvalid_d) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata  = rdata_q;
    assign rvalid = rvalid_q;

    // FIFO empty interrupts by threshold
    assign periodic_fifo_empty_irq = role_q && per_queue_room
        && empty_level(cfg.per_thr, per_fifo_half,
                       per_fifo_full_empty);
    assign nonperiodic_fifo_empty_irq = role_q
        && empty_level(cfg.np_thr, np_fifo_half, np_fifo_full_empty);
    assign in_endpoint_fifo_empty_irq = !role_q
        && empty_level(cfg.np_thr, np_fifo_half, np_fifo_full_empty);

    assign irq = cfg.gate && core_irq;
    assign host_role = role_q;
    assign corrupt_packet_debug = cfg.corrupt;
    assign turnaround_clocks = cfg.turn;

    // Timeout in quarter bit times, calibration added
    assign timeout_quarters_min = 8'(FS_BIT_QUARTERS_MIN) + 8'(cfg.tout);
    assign timeout_quarters_max = 8'(FS_BIT_QUARTERS_MAX) + 8'(cfg.tout);

    property p_force_dev;
        @(posedge clk) disable iff (!rstn)
        cfg.force_dev |=> !role_q;
    endproperty
    a_force_dev: assert property (p_force_dev)
        else $error("forced peripheral role not taken");

    property p_force_hst;
        @(posedge clk) disable iff (!rstn)
        (cfg.force_hst && !cfg.force_dev) |=> role_q;
    endproperty
    a_force_hst: assert property (p_force_hst)
        else $error("forced host role not taken");

    property p_role_read;
        @(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && req.addr == OFS_STATUS_CTRL)
            |=> rvalid && rdata[BIT_ROLE] == $past(role_q)
                && rdata[BIT_IDENT] == $past(ident_q);
    endproperty
    a_role_read: assert property (p_role_read)
        else $error("status read does not show role");

    property p_gate;
        @(posedge clk) disable iff (!rstn)
        irq |-> (cfg.gate && core_irq);
    endproperty
    a_gate: assert property (p_gate)
        else $error("interrupt passed while gated");

    property p_per_thr;
        @(posedge clk) disable iff (!rstn)
        periodic_fifo_empty_irq |-> per_queue_room
            && (cfg.per_thr ? per_fifo_full_empty : per_fifo_half);
    endproperty
    a_per_thr: assert property (p_per_thr)
        else $error("periodic empty irq wrong level");

    property p_turn_write;
        @(posedge clk) disable iff (!rstn)
        wr_usb |=> turnaround_clocks == $past(req.wdata[POS_TURN +: 4]);
    endproperty
    a_turn_write: assert property (p_turn_write)
        else $error("turnaround field not stored");

    property p_tout;
        @(posedge clk) disable iff (!rstn)
        (timeout_quarters_max - timeout_quarters_min) == 8'h08
            && timeout_quarters_min == 8'(FS_BIT_QUARTERS_MIN) + 8'(cfg.tout);
    endproperty
    a_tout: assert property (p_tout)
        else $error("timeout span wrong");

    // Read request shapes shared by the read-back checks
    sequence s_rd_status;
        req.valid && !req.write && req.addr == OFS_STATUS_CTRL;
    endsequence

    sequence s_rd_event;
        req.valid && !req.write && req.addr == OFS_EVENT_STAT;
    endsequence

    sequence s_rd_bus;
        req.valid && !req.write && req.addr == OFS_BUS_CFG;
    endsequence

    sequence s_rd_usb;
        req.valid && !req.write && req.addr == OFS_USB_CFG;
    endsequence

    sequence s_rd_unmapped;
        req.valid && !req.write && req.addr != OFS_STATUS_CTRL
            && req.addr != OFS_EVENT_STAT && req.addr != OFS_BUS_CFG
            && req.addr != OFS_USB_CFG;
    endsequence

    property p_status_resv;
        @(posedge clk) disable iff (!rstn)
        s_rd_status |=> (rdata & 32'hFFDE_FFFF) == 32'h0000_0000;
    endproperty
    a_status_resv: assert property (p_status_resv)
        else $error("status reserved bits not zero");

    property p_event_read;
        @(posedge clk) disable iff (!rstn)
        s_rd_event |=> rdata == ($past(session_end_flag) ? 32'h0000_0004
                                                         : 32'h0000_0000);
    endproperty
    a_event_read: assert property (p_event_read)
        else $error("event read does not show session flag");

    property p_bus_resv;
        @(posedge clk) disable iff (!rstn)
        s_rd_bus |=> (rdata & 32'hFFFF_FE7E) == 32'h0000_0000;
    endproperty
    a_bus_resv: assert property (p_bus_resv)
        else $error("bus config reserved bits not zero");

    property p_usb_resv;
        @(posedge clk) disable iff (!rstn)
        s_rd_usb |=> (rdata & 32'h1FFF_C3F8) == 32'h0000_0000;
    endproperty
    a_usb_resv: assert property (p_usb_resv)
        else $error("usb config reserved bits not zero");

    property p_unmapped;
        @(posedge clk) disable iff (!rstn)
        s_rd_unmapped |=> rvalid && rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_clear;
        @(posedge clk) disable iff (!rstn)
        (clr_one && bus_valid) |=> !session_end_flag;
    endproperty
    a_clear: assert property (p_clear)
        else $error("session flag not cleared by write of one");

    property p_ident;
        @(posedge clk) disable iff (!rstn)
        rstn |=> ident_q == $past(id_pin);
    endproperty
    a_ident: assert property (p_ident)
        else $error("identity flag does not follow pin");

    property p_role_id;
        @(posedge clk) disable iff (!rstn)
        (!cfg.force_dev && !cfg.force_hst) |=> role_q == !$past(id_pin);
    endproperty
    a_role_id: assert property (p_role_id)
        else $error("role not chosen by identity");

    property p_gate_pass;
        @(posedge clk) disable iff (!rstn)
        (cfg.gate && core_irq) |-> irq;
    endproperty
    a_gate_pass: assert property (p_gate_pass)
        else $error("interrupt blocked while unmasked");

    property p_per_room;
        @(posedge clk) disable iff (!rstn)
        (!per_queue_room || !role_q) |-> !periodic_fifo_empty_irq;
    endproperty
    a_per_room: assert property (p_per_room)
        else $error("periodic empty irq without queue room");

    property p_in_route;
        @(posedge clk) disable iff (!rstn)
        in_endpoint_fifo_empty_irq |-> !role_q && !nonperiodic_fifo_empty_irq
            && (cfg.np_thr ? np_fifo_full_empty : np_fifo_half);
    endproperty
    a_in_route: assert property (p_in_route)
        else $error("endpoint empty irq wrong role or level");

    property p_tout_write;
        @(posedge clk) disable iff (!rstn)
        wr_usb |=> timeout_quarters_min
            == 8'(FS_BIT_QUARTERS_MIN) + 8'($past(req.wdata[POS_TOUT +: 3]));
    endproperty
    a_tout_write: assert property (p_tout_write)
        else $error("calibration not added to timeout");

    property p_cfg_hold;
        @(posedge clk) disable iff (!rstn)
        (!wr_bus && !wr_usb) |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without a write");
endmodule
`default_nettype wire

// File: testbench/usb_peer_model.sv
// Behavioural USB peer behind the PHY: identity and VBUS levels.
// Assumes the bench commands attach and peer role through its inputs.
`timescale 1ns/100ps
`default_nettype none
module usb_peer_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic attach,
    input  wire logic a_device,
    output logic      id_pin,
    output logic      bus_valid
);
    // Levels leave synchronous to clk, as the block expects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            id_pin    <= 1'b1;
            bus_valid <= 1'b1;
        end else begin
            id_pin    <= ~a_device;
            bus_valid <= attach;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_otg_global_regs.sv
// Self-checking bench for the global configuration registers.
// Assumes the peer model drives identity and bus-valid levels.
`timescale 1ns/100ps
`default_nettype none
module tb_otg_global_regs;
    import otg_global_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    reg_req_t    req = '0;
    logic        core_irq = 1'b0;
    logic [4:0]  lv = '0;
    logic        attach = 1'b1;
    logic        a_dev = 1'b0;
    logic [31:0] rdata, v, d;
    logic        rvalid, id_pin, bus_valid, irq, host_role;
    logic        p_irq, np_irq, in_irq, corrupt, pk;
    logic [3:0]  turn;
    logic [7:0]  tmin, tmax;
    int          miscompares = 0;
    int          tests_run = 0;

    always #12.5 clk = ~clk; // 40 MHz bus clock

    usb_peer_model peer (.clk(clk), .rstn(rstn), .attach(attach),
        .a_device(a_dev), .id_pin(id_pin), .bus_valid(bus_valid));

    otg_global_regs dut (.clk(clk), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .id_pin(id_pin),
        .bus_valid(bus_valid), .core_irq(core_irq),
        .per_fifo_half(lv[4]), .per_fifo_full_empty(lv[3]),
        .per_queue_room(lv[2]), .np_fifo_half(lv[1]),
        .np_fifo_full_empty(lv[0]), .irq(irq), .host_role(host_role),
        .periodic_fifo_empty_irq(p_irq),
        .nonperiodic_fifo_empty_irq(np_irq),
        .in_endpoint_fifo_empty_irq(in_irq),
        .corrupt_packet_debug(corrupt), .turnaround_clocks(turn),
        .timeout_quarters_min(tmin), .timeout_quarters_max(tmax));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        @(posedge clk);
        req <= '{1'b1, 1'b1, a, dat};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, 32'h0};
        @(posedge clk);
        req <= '0;
        #1;
        check({31'h0, rvalid}, 32'h1);
        check(rdata, exp);
    endtask

    function automatic logic pick(input logic thr, half, full);
        return thr ? full : half;
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        miscompares++;
        final_report();
    end

    initial begin
        void'($urandom(32'h4f99fa38));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        tick(3);
        check({28'h0, turn}, 32'h5);
        rd_chk(OFS_STATUS_CTRL, 32'h0001_0000);
        rd_chk(OFS_EVENT_STAT, 32'h0);
        rd_chk(OFS_BUS_CFG, 32'h0);
        rd_chk(OFS_USB_CFG, 32'h0000_1400);
        rd_chk(12'h010, 32'h0);
        wr(OFS_BUS_CFG, 32'hFFFF_FFFF);
        rd_chk(OFS_BUS_CFG, 32'h0000_0181);
        wr(OFS_STATUS_CTRL, 32'hFFFF_FFFF);
        rd_chk(OFS_STATUS_CTRL, 32'h0001_0000);
        // Random gate, thresholds, levels and peer role
        for (int i = 0; i < 48; i++) begin
            v = $urandom;
            wr(OFS_BUS_CFG, v);
            @(posedge clk);
            core_irq <= v[31];
            lv <= v[15:11];
            a_dev <= v[30];
            tick(3);
            pk = pick(v[7], v[12], v[11]);
            check({31'h0, host_role}, {31'h0, v[30]});
            check({31'h0, irq}, {31'h0, v[0] & v[31]});
            check({31'h0, np_irq}, {31'h0, v[30] & pk});
            check({31'h0, in_irq}, {31'h0, ~v[30] & pk});
            if (v[30]) begin
                check({31'h0, p_irq},
                    {31'h0, pick(v[8], v[15], v[14]) & v[13]});
            end
            rd_chk(OFS_BUS_CFG, v & 32'h0000_0181);
        end
        // Forced roles against the identity input
        @(posedge clk);
        a_dev <= 1'b0;
        tick(3);
        wr(OFS_USB_CFG, 32'h2000_1400);
        tick(1); // Role settles in a cycle
        check({31'h0, host_role}, 32'h1);
        rd_chk(OFS_STATUS_CTRL, 32'h0021_0000);
        wr(OFS_USB_CFG, 32'h6000_1400);
        tick(1);
        check({31'h0, host_role}, 32'h0);
        @(posedge clk);
        a_dev <= 1'b1;
        tick(3);
        check({31'h0, host_role}, 32'h0);
        rd_chk(OFS_STATUS_CTRL, 32'h0);
        wr(OFS_USB_CFG, 32'h0000_1400);
        tick(1);
        check({31'h0, host_role}, 32'h1);
        // Timeout calibration over every code
        for (int c = 0; c < 8; c++) begin
            v = $urandom;
            d = (v[0] ? 32'h0000_2400 : 32'h0000_1400) | 32'(c);
            wr(OFS_USB_CFG, d);
            check({24'h0, tmin}, 32'h40 + 32'(c));
            check({24'h0, tmax}, 32'h48 + 32'(c));
            check({28'h0, turn}, {28'h0, d[13:10]});
            check({31'h0, corrupt}, {31'h0, d[31]});
            rd_chk(OFS_USB_CFG, d);
        end
        // Session end: set by hardware, cleared by writing one
        rd_chk(OFS_EVENT_STAT, 32'h0);
        @(posedge clk);
        attach <= 1'b0;
        tick(4);
        rd_chk(OFS_EVENT_STAT, 32'h4);
        wr(OFS_EVENT_STAT, 32'hFFFF_FFFB);
        rd_chk(OFS_EVENT_STAT, 32'h4);
        wr(OFS_EVENT_STAT, 32'h4);
        rd_chk(OFS_EVENT_STAT, 32'h0);
        @(posedge clk);
        attach <= 1'b1;
        tick(4);
        rd_chk(OFS_EVENT_STAT, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
